// ==== mpsu_pkg.sv ====
package mpsu_pkg;
  localparam int unsigned MPSU_DIV_W = 16;
  localparam logic [15:0] MPSU_DIV_RESET = 16'h0002;
  localparam logic [15:0] MPSU_CNT_END = 16'h0001;
  localparam int unsigned MPSU_DLAB_BIT = 7;
  localparam logic MPSU_DLAB_RESET = 1'b0;
  localparam logic [7:0] MPSU_LCR_RESET = 8'h00;
  localparam logic [1:0] MPSU_SEL_RESET = 2'h0;
  typedef enum logic [1:0] {
    MPSU_SEL_OFF  = 2'h0,
    MPSU_SEL_UART = 2'h1,
    MPSU_SEL_SPI  = 2'h2,
    MPSU_SEL_I2C  = 2'h3
  } mpsu_sel_t;
endpackage : mpsu_pkg

// ==== mpsu_baud_pulse_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - 16-bit counter decrements each clock while above 0001h.
// - After reaching 0001h, next edge reloads divisor and pulses end-of-count.
// - Pulse rate equals clock divided by the high-over-low 16-bit divisor.
// - Divisor resets to 0002h.
// - Divisor 0001h is valid and pulses every clock.
// - Writing either divisor byte loads both into counter, restarting count.
// - Divisor bytes reachable only while divisor-access bit is set.
// - Divisor-access bit clears on reset.
// - With no controller selected the counter holds and no pulse is given; accepted divisor writes still reload it.
// - Pulse clocks SPI and UART; I2C runs from system clock.
// - At most one controller enabled at a time.
// - Select 00 none, 01 UART, 10 SPI, 11 I2C.
module mpsu_baud_pulse_divider #(
  parameter int unsigned DIV_W = mpsu_pkg::MPSU_DIV_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Controller select and line control
  input wire logic [1:0] controller_select_field,
  input wire logic lcr_wr,
  input wire logic [7:0] lcr_wdata,
  // Divisor byte writes, one-cycle strobes
  input wire logic div_lo_wr,
  input wire logic div_hi_wr,
  input wire logic [7:0] div_wdata,
  // State seen by software
  output logic [7:0] line_control_register,
  output logic [7:0] divisor_low_byte,
  output logic [7:0] divisor_high_byte,
  // Controller enables and timing
  output logic uart_en,
  output logic spi_en,
  output logic i2c_en,
  output logic baud_pulse,
  output logic uart_baud_tick,
  output logic spi_baud_tick
);
  import mpsu_pkg::*;

  logic [DIV_W-1:0] count;
  logic dlab;
  logic unit_active;
  logic lo_access;
  logic hi_access;
  logic [DIV_W-1:0] next_divisor;
  logic [DIV_W-1:0] since_pulse;
  logic period_clean;

  assign dlab = line_control_register[MPSU_DLAB_BIT];
  assign unit_active = (controller_select_field != MPSU_SEL_OFF);
  // Writes with access bit low belong to other registers at the same address
  assign lo_access = div_lo_wr && dlab;
  assign hi_access = div_hi_wr && dlab;
  assign next_divisor = {hi_access ? div_wdata : divisor_high_byte,
                         lo_access ? div_wdata : divisor_low_byte};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_control_register <= MPSU_LCR_RESET;
    end else if (lcr_wr) begin
      line_control_register <= lcr_wdata;
    end
  end

  // Divisor latches stay writable while the unit idles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {divisor_high_byte, divisor_low_byte} <= MPSU_DIV_RESET;
    end else begin
      {divisor_high_byte, divisor_low_byte} <= next_divisor;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= MPSU_DIV_RESET;
      baud_pulse <= 1'b0;
    end else if (lo_access || hi_access) begin
      count <= next_divisor;
      baud_pulse <= 1'b0;
    end else if (!unit_active) begin
      baud_pulse <= 1'b0;
    end else if (count > MPSU_CNT_END) begin
      count <= count - 16'h0001;
      baud_pulse <= 1'b0;
    end else begin
      // Divisor 0001h reloads every edge: pulse each clock; 0000h unsupported
      count <= {divisor_high_byte, divisor_low_byte};
      baud_pulse <= 1'b1;
    end
  end

  // One-hot decode keeps controllers mutually exclusive
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uart_en <= 1'b0;
      spi_en <= 1'b0;
      i2c_en <= 1'b0;
    end else begin
      uart_en <= (controller_select_field == MPSU_SEL_UART);
      spi_en <= (controller_select_field == MPSU_SEL_SPI);
      i2c_en <= (controller_select_field == MPSU_SEL_I2C);
    end
  end

  // Ticks gated per controller; I2C gets no tick and uses clk directly
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uart_baud_tick <= 1'b0;
      spi_baud_tick <= 1'b0;
    end else begin
      uart_baud_tick <= 1'b0;
      spi_baud_tick <= 1'b0;
      if (lo_access || hi_access || !unit_active) begin
        uart_baud_tick <= 1'b0;
      end else if (count <= MPSU_CNT_END) begin
        uart_baud_tick <= (controller_select_field == MPSU_SEL_UART);
        spi_baud_tick <= (controller_select_field == MPSU_SEL_SPI);
      end
    end
  end

  // Assertion helper: cycles since the last undisturbed pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_pulse <= '0;
      period_clean <= 1'b0;
    end else if (lo_access || hi_access || !unit_active) begin
      since_pulse <= '0;
      period_clean <= 1'b0;
    end else if (baud_pulse) begin
      since_pulse <= DIV_W'(1);
      period_clean <= 1'b1;
    end else begin
      since_pulse <= since_pulse + DIV_W'(1);
    end
  end

  property p_count_dec;
    @(posedge clk) disable iff (!rstn)
      (unit_active && !lo_access && !hi_access && count > MPSU_CNT_END) |=> (count == $past(count) - 16'h0001);
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("counter did not decrement");

  sequence s_at_end;
    unit_active && !lo_access && !hi_access && count == MPSU_CNT_END;
  endsequence
  property p_reload;
    @(posedge clk) disable iff (!rstn)
      s_at_end |=> (baud_pulse && count == {divisor_high_byte, divisor_low_byte});
  endproperty
  a_reload: assert property (p_reload) else $error("no reload and pulse at end of count");

  property p_period;
    @(posedge clk) disable iff (!rstn)
      (baud_pulse && count == 16'h0003 && divisor_high_byte == 8'h00 && divisor_low_byte == 8'h03
       && unit_active && !div_lo_wr && !div_hi_wr) ##1 (unit_active && !div_lo_wr && !div_hi_wr)[*2]
      |=> baud_pulse;
  endproperty
  a_period: assert property (p_period) else $error("pulse period differs from divisor");

  property p_reset_div;
    @(posedge clk) $rose(rstn) |-> ({divisor_high_byte, divisor_low_byte} == MPSU_DIV_RESET && !dlab);
  endproperty
  a_reset_div: assert property (p_reset_div) else $error("reset values wrong");

  property p_div_one;
    @(posedge clk) disable iff (!rstn)
      (count == MPSU_CNT_END && {divisor_high_byte, divisor_low_byte} == MPSU_CNT_END && unit_active
       && !lo_access && !hi_access)[*2] |=> baud_pulse;
  endproperty
  a_div_one: assert property (p_div_one) else $error("divisor one did not pulse each clock");

  property p_write_load;
    @(posedge clk) disable iff (!rstn)
      (lo_access || hi_access) |=> (count == {divisor_high_byte, divisor_low_byte} && !baud_pulse);
  endproperty
  a_write_load: assert property (p_write_load) else $error("divisor write did not restart count");

  property p_no_access;
    @(posedge clk) disable iff (!rstn)
      ((div_lo_wr || div_hi_wr) && !dlab) |=> $stable({divisor_high_byte, divisor_low_byte});
  endproperty
  a_no_access: assert property (p_no_access) else $error("divisor changed without access bit");

  property p_idle;
    @(posedge clk) disable iff (!rstn)
      (!unit_active && !lo_access && !hi_access) |=> (!baud_pulse && $stable(count));
  endproperty
  a_idle: assert property (p_idle) else $error("generator ran while unit idle");

  property p_i2c_tick;
    @(posedge clk) disable iff (!rstn)
      (controller_select_field == MPSU_SEL_I2C) |=> (!uart_baud_tick && !spi_baud_tick);
  endproperty
  a_i2c_tick: assert property (p_i2c_tick) else $error("tick given while I2C selected");

  property p_onehot;
    @(posedge clk) disable iff (!rstn)
      $onehot0({uart_en, spi_en, i2c_en});
  endproperty
  a_onehot: assert property (p_onehot) else $error("controller enables not exclusive");

  property p_one_cycle;
    @(posedge clk) disable iff (!rstn)
      (baud_pulse && {divisor_high_byte, divisor_low_byte} > MPSU_CNT_END && !div_lo_wr && !div_hi_wr)
      |=> !baud_pulse;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("pulse longer than one cycle");

  property p_period_any;
    @(posedge clk) disable iff (!rstn)
      (baud_pulse && period_clean && {divisor_high_byte, divisor_low_byte} != 16'h0000)
      |-> (since_pulse == {divisor_high_byte, divisor_low_byte});
  endproperty
  a_period_any: assert property (p_period_any) else $error("pulse spacing differs from divisor");

  property p_uart_tick;
    @(posedge clk) disable iff (!rstn)
      uart_baud_tick == (baud_pulse && $past(controller_select_field) == MPSU_SEL_UART);
  endproperty
  a_uart_tick: assert property (p_uart_tick) else $error("uart tick does not match pulse");

  property p_spi_tick;
    @(posedge clk) disable iff (!rstn)
      spi_baud_tick == (baud_pulse && $past(controller_select_field) == MPSU_SEL_SPI);
  endproperty
  a_spi_tick: assert property (p_spi_tick) else $error("spi tick does not match pulse");

  sequence s_lo_write;
    div_lo_wr && dlab;
  endsequence
  property p_lo_load;
    @(posedge clk) disable iff (!rstn)
      s_lo_write |=> (divisor_low_byte == $past(div_wdata));
  endproperty
  a_lo_load: assert property (p_lo_load) else $error("low divisor byte not written");

  sequence s_hi_write;
    div_hi_wr && dlab;
  endsequence
  property p_hi_load;
    @(posedge clk) disable iff (!rstn)
      s_hi_write |=> (divisor_high_byte == $past(div_wdata));
  endproperty
  a_hi_load: assert property (p_hi_load) else $error("high divisor byte not written");

  property p_lcr_write;
    @(posedge clk) disable iff (!rstn)
      lcr_wr |=> (line_control_register == $past(lcr_wdata));
  endproperty
  a_lcr_write: assert property (p_lcr_write) else $error("line control not written");

  property p_lcr_hold;
    @(posedge clk) disable iff (!rstn)
      !lcr_wr |=> $stable(line_control_register);
  endproperty
  a_lcr_hold: assert property (p_lcr_hold) else $error("line control changed without write");

  property p_div_hold;
    @(posedge clk) disable iff (!rstn)
      !(lo_access || hi_access) |=> $stable({divisor_high_byte, divisor_low_byte});
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divisor changed without accepted write");

  property p_pulse_at_end;
    @(posedge clk) disable iff (!rstn)
      baud_pulse |-> ($past(count) <= MPSU_CNT_END && $past(unit_active)
        && !$past(lo_access) && !$past(hi_access));
  endproperty
  a_pulse_at_end: assert property (p_pulse_at_end) else $error("pulse raised away from end of count");

  property p_sel_uart;
    @(posedge clk) disable iff (!rstn)
      (controller_select_field == MPSU_SEL_UART) |=> (uart_en && !spi_en && !i2c_en);
  endproperty
  a_sel_uart: assert property (p_sel_uart) else $error("uart select not decoded");

  property p_sel_spi;
    @(posedge clk) disable iff (!rstn)
      (controller_select_field == MPSU_SEL_SPI) |=> (spi_en && !uart_en && !i2c_en);
  endproperty
  a_sel_spi: assert property (p_sel_spi) else $error("spi select not decoded");

  property p_sel_i2c;
    @(posedge clk) disable iff (!rstn)
      (controller_select_field == MPSU_SEL_I2C) |=> (i2c_en && !uart_en && !spi_en);
  endproperty
  a_sel_i2c: assert property (p_sel_i2c) else $error("i2c select not decoded");

  property p_sel_off;
    @(posedge clk) disable iff (!rstn)
      (controller_select_field == MPSU_SEL_OFF) |=> !(uart_en || spi_en || i2c_en);
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("controller enabled while none selected");

  property p_count_range;
    @(posedge clk) disable iff (!rstn)
      ({divisor_high_byte, divisor_low_byte} != 16'h0000)
      |-> (count != 16'h0000 && count <= {divisor_high_byte, divisor_low_byte});
  endproperty
  a_count_range: assert property (p_count_range) else $error("counter outside divisor range");

  property p_idle_ticks;
    @(posedge clk) disable iff (!rstn)
      !unit_active |=> (!uart_baud_tick && !spi_baud_tick);
  endproperty
  a_idle_ticks: assert property (p_idle_ticks) else $error("tick given while unit idle");

  property p_reset_out;
    @(posedge clk) $rose(rstn) |-> (count == MPSU_DIV_RESET && !baud_pulse && !uart_baud_tick
      && !spi_baud_tick && !uart_en && !spi_en && !i2c_en);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not at reset values");

  property p_tick_width;
    @(posedge clk) disable iff (!rstn)
      (uart_baud_tick && {divisor_high_byte, divisor_low_byte} > MPSU_CNT_END && !div_lo_wr && !div_hi_wr)
      |=> !uart_baud_tick;
  endproperty
  a_tick_width: assert property (p_tick_width) else $error("tick longer than one cycle");
endmodule : mpsu_baud_pulse_divider
`default_nettype wire

// ==== mpsu_port_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpsu_port_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Baud ticks from the divider
  input wire logic uart_baud_tick,
  input wire logic spi_baud_tick,
  // Tick tallies of each controller
  output var int uart_ticks,
  output var int spi_ticks
);
  // Stands in for the two controllers that the ticks clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uart_ticks <= 0;
      spi_ticks <= 0;
    end else begin
      uart_ticks <= uart_ticks + int'(uart_baud_tick);
      spi_ticks <= spi_ticks + int'(spi_baud_tick);
    end
  end
endmodule : mpsu_port_model
`default_nettype wire

// ==== mpsu_baud_pulse_divider_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpsu_baud_pulse_divider_tb;
  import mpsu_pkg::*;
  logic clk, rstn, lcr_wr, lo_wr, hi_wr, bp, ut, st, u_en, s_en, i_en;
  logic [1:0] sel;
  logic [7:0] wd, lcr, dlo, dhi;
  int bad_count, cmp_count, n, u0, s0, uc, sc;
  int cyc = 0;
  mpsu_baud_pulse_divider i_mpsu_baud_pulse_divider (.clk(clk), .rstn(rstn), .controller_select_field(sel),
    .lcr_wr(lcr_wr), .lcr_wdata(wd), .div_lo_wr(lo_wr), .div_hi_wr(hi_wr), .div_wdata(wd),
    .line_control_register(lcr), .divisor_low_byte(dlo), .divisor_high_byte(dhi), .uart_en(u_en),
    .spi_en(s_en), .i2c_en(i_en), .baud_pulse(bp), .uart_baud_tick(ut), .spi_baud_tick(st));
  mpsu_port_model i_mpsu_port_model (.clk(clk), .rstn(rstn), .uart_baud_tick(ut), .spi_baud_tick(st),
    .uart_ticks(uc), .spi_ticks(sc));
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input int k, input logic [7:0] d);
    @(posedge clk);
    lcr_wr <= (k == 0);
    lo_wr <= (k == 1);
    hi_wr <= (k == 2);
    wd <= d;
    @(posedge clk);
    lcr_wr <= 1'b0;
    lo_wr <= 1'b0;
    hi_wr <= 1'b0;
    @(negedge clk);
  endtask : wr
  task to_pulse;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bp !== 1'b1 && n < 300);
  endtask : to_pulse
  task gap(input string what, input int exp);
    to_pulse();
    to_pulse();
    check(what, 16'(n), 16'(exp));
    @(negedge clk);
    if (exp > 1) check("pulse width", 16'(bp), 16'h0000);
    else check("pulse each clock", 16'(bp), 16'h0001);
  endtask : gap
  // Tick deltas over a window of whole cycles
  task ticks(input int c);
    u0 = uc;
    s0 = sc;
    repeat (c) @(negedge clk);
    u0 = uc - u0;
    s0 = sc - s0;
  endtask : ticks
  task set_sel(input logic [1:0] s, input logic [2:0] en);
    @(posedge clk);
    sel <= s;
    repeat (2) @(negedge clk);
    check("enables", 16'({u_en, s_en, i_en}), 16'(en));
  endtask : set_sel
  task t_reset;
    @(negedge clk);
    check("lcr", 16'(lcr), 16'h0000);
    check("divisor", {dhi, dlo}, MPSU_DIV_RESET);
    repeat (20) @(negedge clk) check("idle pulse", 16'(bp), 16'h0000);
  endtask : t_reset
  task t_uart;
    set_sel(MPSU_SEL_UART, 3'h4);
    gap("reset period", 2);
    ticks(20);
    check("uart ticks", 16'(u0), 16'h000a);
    check("spi ticks", 16'(s0), 16'h0000);
  endtask : t_uart
  task t_prog;
    wr(1, 8'h09);
    check("low refused", 16'(dlo), 16'h0002);
    wr(0, 8'h80);
    check("lcr written", 16'(lcr), 16'h0080);
    wr(1, 8'h05);
    to_pulse();
    check("restart", 16'(n), 16'h0005);
    gap("period 5", 5);
    wr(2, 8'h01);
    check("divisor", {dhi, dlo}, 16'h0105);
    gap("period 261", 261);
    wr(2, 8'h00);
    wr(1, 8'h03);
    gap("period 3", 3);
    wr(1, 8'h01);
    gap("period 1", 1);
    wr(0, 8'h00);
    wr(1, 8'h07);
    check("low locked", 16'(dlo), 16'h0001);
  endtask : t_prog
  task t_sel;
    set_sel(MPSU_SEL_SPI, 3'h2);
    ticks(10);
    check("spi ticks", 16'(s0), 16'h000a);
    check("uart ticks", 16'(u0), 16'h0000);
    set_sel(MPSU_SEL_I2C, 3'h1);
    ticks(10);
    check("i2c ticks", 16'(u0 + s0), 16'h0000);
    set_sel(MPSU_SEL_OFF, 3'h0);
    repeat (5) @(negedge clk) check("off pulse", 16'(bp), 16'h0000);
  endtask : t_sel
  task t_rerun;
    wr(0, 8'h80);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("lcr after reset", 16'(lcr), 16'h0000);
    check("divisor after reset", {dhi, dlo}, MPSU_DIV_RESET);
    set_sel(MPSU_SEL_UART, 3'h4);
    gap("period after reset", 2);
  endtask : t_rerun
  task end_sim;
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard well beyond the longest scenario
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    {rstn, lcr_wr, lo_wr, hi_wr, sel, wd} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_uart();
    t_prog();
    t_sel();
    t_rerun();
    end_sim();
  end
endmodule : mpsu_baud_pulse_divider_tb
`default_nettype wire
